// *** rtl/stc_pkg.sv ***
// Package: register map, field positions and carriers for the 16-bit timer
package stc_pkg;

    // ************************************************************
    // Register map (byte registers on a plain port)
    // ************************************************************
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_COUNT_LO = 2'h1;
    localparam logic [1:0] ADDR_COUNT_HI = 2'h2;
    localparam logic [1:0] ADDR_IRQ = 2'h3;

    // ************************************************************
    // Control and IRQ register fields
    // ************************************************************
    localparam int BIT_RUN = 0;
    localparam int BIT_CLK_SRC = 1;
    localparam int BIT_SYNC_BYPASS = 2;
    localparam int BIT_CAP_LO = 3;
    localparam int BIT_PRESCALE_LO = 4;
    localparam int BIT_CAP_HI = 6;
    localparam int BIT_WIDE = 7;
    localparam int BIT_IRQ_FLAG = 0;
    localparam int BIT_IRQ_EN = 1;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [2:0] PRESCALE_RESET = 3'h0;
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
    localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hb;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } stc_bus_t;

    typedef struct packed {
        logic [7:0] control_q;
        logic [15:0] count_q;
        logic [7:0] hi_buf_q;
        logic [2:0] pre_q;
        logic [1:0] instr_q;
        logic ext_prev_q;
        logic armed_q;
        logic flag_q;
        logic irq_en_q;
        logic [7:0] rdata_q;
        logic adc_start_q;
    } stc_state_t;

endpackage

// *** rtl/stc_timer.sv ***
// Module: 16-bit up timer/counter with prescaler and byte register port
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module stc_timer
(
    input wire logic clk,
    input wire logic rst,
    input wire stc_pkg::stc_bus_t bus,
    output logic [7:0] rdata,
    input wire logic ext_clock_pin,
    input wire logic low_speed_osc_enable,
    input wire logic [3:0] unit1_mode,
    input wire logic [3:0] unit2_mode,
    input wire logic unit1_trigger,
    input wire logic unit2_trigger,
    input wire logic adc_enabled,
    input wire logic [1:0] port_c_pin_in,
    input wire logic [1:0] port_c_direction,
    output logic [1:0] port_c_read,
    output logic [1:0] port_c_oe_n,
    output logic unit1_uses_this,
    output logic unit2_uses_this,
    output logic overflow_flag,
    output logic irq,
    output logic adc_start,
    output logic [15:0] count
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [2:0] pre_mask(input logic [1:0] sel);
        case (sel)
            2'h0: pre_mask = 3'h0;
            2'h1: pre_mask = 3'h1;
            2'h2: pre_mask = 3'h3;
            default: pre_mask = 3'h7;
        endcase
    endfunction

    stc_pkg::stc_state_t s_q;
    stc_pkg::stc_state_t s_d;
    logic [1:0] pin_sync_q;
    logic ext_sync3_q;
    logic [1:0] port_meta_q;
    logic [1:0] port_sync_q;
    logic wide;
    logic src_ext;
    logic ext_level;
    logic ext_rise;
    logic tick;
    logic pre_done;
    logic trig1;
    logic trig2;
    logic lo_wr;
    logic hi_wr;

    // ************************************************************
    // External clock capture
    // ************************************************************
    // Every pin passes two flops against metastability. True async
    // counting is not possible in one domain, so bypass keeps those
    // two flops and the synchronised path adds a third stage
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin_sync_q <= 2'h0;
            ext_sync3_q <= 1'b0;
            port_meta_q <= 2'h0;
            port_sync_q <= 2'h0;
        end
        else
        begin
            pin_sync_q <= {pin_sync_q[0], ext_clock_pin};
            ext_sync3_q <= pin_sync_q[1];
            port_meta_q <= port_c_pin_in;
            port_sync_q <= port_meta_q;
        end
    end

    always_comb
    begin
        wide = s_q.control_q[stc_pkg::BIT_WIDE];
        src_ext = s_q.control_q[stc_pkg::BIT_CLK_SRC];
        ext_level = s_q.control_q[stc_pkg::BIT_SYNC_BYPASS]
            ? pin_sync_q[1] : ext_sync3_q;
        ext_rise = s_q.armed_q && ext_level && !s_q.ext_prev_q;
        tick = src_ext ? ext_rise
            : (s_q.instr_q == stc_pkg::INSTR_DIV_LAST);
        pre_done = (s_q.pre_q & pre_mask(
            s_q.control_q[stc_pkg::BIT_PRESCALE_LO +: 2]))
            == pre_mask(s_q.control_q[stc_pkg::BIT_PRESCALE_LO +: 2]);
        unit1_uses_this = s_q.control_q[stc_pkg::BIT_CAP_HI];
        unit2_uses_this = s_q.control_q[stc_pkg::BIT_CAP_HI]
            | s_q.control_q[stc_pkg::BIT_CAP_LO];
        trig1 = unit1_trigger && unit1_uses_this
            && unit1_mode == stc_pkg::MODE_SPECIAL_EVENT;
        trig2 = unit2_trigger && unit2_uses_this
            && unit2_mode == stc_pkg::MODE_SPECIAL_EVENT;
        lo_wr = bus.wr && bus.addr == stc_pkg::ADDR_COUNT_LO;
        hi_wr = bus.wr && bus.addr == stc_pkg::ADDR_COUNT_HI;
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.adc_start_q = 1'b0;
        s_d.instr_q = s_q.instr_q + 2'h1;
        s_d.ext_prev_q = ext_level;
        if (!src_ext)
            s_d.armed_q = 1'b0;
        else if (!ext_level)
            s_d.armed_q = 1'b1;
        if (s_q.control_q[stc_pkg::BIT_RUN] && tick)
        begin
            if (pre_done)
            begin
                s_d.pre_q = stc_pkg::PRESCALE_RESET;
                s_d.count_q = s_q.count_q + 16'h0001;
                // A trigger in the same cycle replaces the wrap
                if (s_q.count_q == stc_pkg::COUNT_MAX && !(trig1 || trig2))
                    s_d.flag_q = 1'b1;
            end
            else
                s_d.pre_q = s_q.pre_q + 3'h1;
        end
        // Trigger reset leaves flag alone
        if (trig1 || trig2)
        begin
            s_d.count_q = stc_pkg::COUNT_RESET;
            s_d.pre_q = stc_pkg::PRESCALE_RESET;
        end
        s_d.adc_start_q = trig2 && adc_enabled;
        // Writes come last so they win over the trigger
        if (bus.wr)
        begin
            if (bus.addr == stc_pkg::ADDR_CONTROL)
                s_d.control_q = bus.wdata;
            else if (lo_wr)
            begin
                s_d.count_q[7:0] = bus.wdata;
                if (wide)
                    s_d.count_q[15:8] = s_q.hi_buf_q;
                s_d.pre_q = stc_pkg::PRESCALE_RESET;
            end
            else if (hi_wr)
            begin
                if (wide)
                    s_d.hi_buf_q = bus.wdata;
                else
                    s_d.count_q[15:8] = bus.wdata;
            end
            else if (bus.addr == stc_pkg::ADDR_IRQ)
            begin
                // Hardware set wins over a software clear only while the flag is low
                s_d.flag_q = bus.wdata[stc_pkg::BIT_IRQ_FLAG]
                    | (s_d.flag_q & ~s_q.flag_q);
                s_d.irq_en_q = bus.wdata[stc_pkg::BIT_IRQ_EN];
            end
        end
        s_d.rdata_q = 8'h00;
        if (bus.rd)
        begin
            if (bus.addr == stc_pkg::ADDR_CONTROL)
                s_d.rdata_q = s_q.control_q;
            else if (bus.addr == stc_pkg::ADDR_COUNT_LO)
            begin
                s_d.rdata_q = s_q.count_q[7:0];
                if (wide)
                    s_d.hi_buf_q = s_q.count_q[15:8];
            end
            else if (bus.addr == stc_pkg::ADDR_COUNT_HI)
                s_d.rdata_q = wide ? s_q.hi_buf_q
                    : s_q.count_q[15:8];
            else
                s_d.rdata_q = {6'h00, s_q.irq_en_q, s_q.flag_q};
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_comb
    begin
        rdata = s_q.rdata_q;
        count = s_q.count_q;
        overflow_flag = s_q.flag_q;
        irq = s_q.flag_q && s_q.irq_en_q;
        adc_start = s_q.adc_start_q;
        // Oscillator pins become inputs and read zero
        port_c_oe_n = low_speed_osc_enable ? 2'h3 : port_c_direction;
        port_c_read = low_speed_osc_enable ? 2'h0 : port_sync_q;
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    stop_holds_a: assert property (
        !s_q.control_q[0] && !trig1 && !trig2 && !bus.wr
        |=> s_q.count_q == $past(s_q.count_q))
        else $error("Counter moved while stopped");
    wrap_flag_a: assert property (
        s_q.count_q == 16'hffff && s_d.count_q == 16'h0000
        && !trig1 && !trig2 && !bus.wr |=> s_q.flag_q)
        else $error("Wrap did not set flag");
    trig_clear_a: assert property (
        (trig1 || trig2) && !bus.wr |=> s_q.count_q == 16'h0000)
        else $error("Trigger did not clear counter");
    write_wins_a: assert property (
        (trig1 || trig2) && lo_wr && !wide
        |=> s_q.count_q[7:0] == $past(bus.wdata))
        else $error("Trigger beat software write");
    trig_noflag_a: assert property (
        (trig1 || trig2) && !s_q.flag_q && !bus.wr |=> !s_q.flag_q)
        else $error("Trigger set the flag");
    lo_snap_a: assert property (
        bus.rd && bus.addr == 2'h1 && wide
        |=> s_q.hi_buf_q == $past(s_q.count_q[15:8]))
        else $error("High byte not snapshotted");
    wide_hi_a: assert property (
        hi_wr && wide && !trig1 && !trig2
        ##1 lo_wr && !trig1 && !trig2
        |=> s_q.count_q[15:8] == $past(bus.wdata, 2))
        else $error("Buffered high byte not loaded");
    lo_prescale_a: assert property (
        lo_wr |=> s_q.pre_q == 3'h0)
        else $error("Prescaler not cleared");
    adc_go_a: assert property (
        trig2 && adc_enabled |=> adc_start)
        else $error("Conversion start missing");
    irq_gate_a: assert property (
        !s_q.irq_en_q |-> !irq)
        else $error("Interrupt raised while disabled");
    osc_pins_a: assert property (
        low_speed_osc_enable |-> port_c_read == 2'h0)
        else $error("Oscillator pins read nonzero");
    osc_oe_a: assert property (
        low_speed_osc_enable |-> port_c_oe_n == 2'h3)
        else $error("Oscillator pins driven");
    hi_keep_pre_a: assert property (
        hi_wr && !trig1 && !trig2 && !s_q.control_q[0]
        |=> s_q.pre_q == $past(s_q.pre_q))
        else $error("High write touched prescaler");
    wide_no_direct_a: assert property (
        hi_wr && wide && !trig1 && !trig2 && !s_q.control_q[0]
        |=> s_q.count_q == $past(s_q.count_q))
        else $error("Wide high write reached counter");
    count_step_a: assert property (
        !bus.wr && !trig1 && !trig2
        |=> s_q.count_q == $past(s_q.count_q)
        || s_q.count_q == $past(s_q.count_q) + 16'h0001)
        else $error("Counter skipped a value");
    adc_quiet_a: assert property (
        !adc_enabled |=> !adc_start)
        else $error("Conversion start while disabled");
    rdata_idle_a: assert property (
        !bus.rd |=> rdata == 8'h00)
        else $error("Read data outside read cycle");

    wrap_c: cover property (s_q.count_q == 16'hffff ##1 s_q.flag_q);
    trig_c: cover property (trig2 && adc_enabled);
    wide_c: cover property (hi_wr && wide ##1 lo_wr);
    ext_c: cover property (src_ext && ext_rise && pre_done);
    // Trigger together with a software write, the precedence case
    write_trig_c: cover property ((trig1 || trig2) && lo_wr);

endmodule // stc_timer

// *** dv/stc_ext_osc.sv ***
// External clock source model feeding the timer's clock pin
`timescale 1ns/1ps
module stc_ext_osc
#(
    parameter int HALF = 5
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    output logic pin
);
    int cnt_q;
    // Held low while stopped so no stray edge reaches the counter
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= 0;
            pin <= 1'b0;
        end
        else if (!run)
        begin
            cnt_q <= 0;
            pin <= 1'b0;
        end
        else if (cnt_q == HALF - 1)
        begin
            cnt_q <= 0;
            pin <= !pin;
        end
        else
        begin
            cnt_q <= cnt_q + 1;
        end
    end
endmodule // stc_ext_osc

// *** dv/stc_timer_tb.sv ***
// Self-checking bench for the 16-bit timer through its byte port
`timescale 1ns/1ps
module stc_timer_tb;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic clk, rst, osc_en, osc_run, adc_en, t1, t2, u1u, u2u;
    logic flag, irq, adcs, ext;
    logic [3:0] m1, m2;
    logic [1:0] pin, dir, prd, oen;
    logic [7:0] rdata, d;
    logic [15:0] count, c0;
    stc_pkg::stc_bus_t bus;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [7:0] ctl [4] = '{8'h00, 8'h08, 8'h40, 8'h48};
    logic [1:0] use_exp [4] = '{2'h0, 2'h1, 2'h3, 2'h3};

    stc_timer u_stc_timer (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
        .ext_clock_pin(ext), .low_speed_osc_enable(osc_en),
        .unit1_mode(m1), .unit2_mode(m2), .unit1_trigger(t1),
        .unit2_trigger(t2), .adc_enabled(adc_en), .port_c_pin_in(pin),
        .port_c_direction(dir), .port_c_read(prd), .port_c_oe_n(oen),
        .unit1_uses_this(u1u), .unit2_uses_this(u2u),
        .overflow_flag(flag), .irq(irq), .adc_start(adcs), .count(count));
    stc_ext_osc u_stc_ext_osc (.clk(clk), .rst(rst), .run(osc_run),
        .pin(ext));

    // ****************************************
    // Bus tasks and checks
    // ****************************************
    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Strobe dropped, then one idle edge so no strobe is set twice at once
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 v = rdata;
        @(posedge clk);
    endtask

    // Two samples a fixed span apart, so start phase drops out
    task automatic rate(input logic [7:0] c, input int cyc,
        input logic [15:0] n);
        wr(stc_pkg::ADDR_CONTROL, c);
        repeat (8) @(posedge clk);
        #1 c0 = count;
        repeat (cyc) @(posedge clk);
        #1 chk(18'(count - c0), 18'(n));
        @(posedge clk);
    endtask

    task automatic fire(input logic a, input logic b, input logic w);
        @(posedge clk);
        t1 <= a;
        t2 <= b;
        bus.addr <= stc_pkg::ADDR_COUNT_LO;
        bus.wdata <= 8'h5a;
        bus.wr <= w;
        @(posedge clk);
        t1 <= 1'b0;
        t2 <= 1'b0;
        bus.wr <= 1'b0;
        #1;
    endtask

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ****************************************
    // Clock, watchdog and test sequence
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up;
    end

    initial
    begin
        rst = 1'b1;
        bus = '0;
        {osc_en, osc_run, adc_en, t1, t2, m1, m2, dir} = '0;
        pin = 2'h3;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 4; a++)
        begin
            rd(2'(a), d);
            chk(18'(d), 18'h0);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(stc_pkg::ADDR_CONTROL, ctl[i]);
            chk(18'({u1u, u2u}), 18'(use_exp[i]));
        end
        for (int p = 0; p < 4; p++)
            rate({2'h0, 2'(p), 4'h1}, 32 << p, 16'h0008);
        rate(8'h05, 32, 16'h0008);
        rate(8'h00, 64, 16'h0000);
        osc_en <= 1'b1;
        osc_run <= 1'b1;
        @(posedge clk);
        #1 chk(18'({prd, oen}), 18'h3);
        @(posedge clk);
        rate(8'h03, 100, 16'h000a);
        rate(8'h07, 100, 16'h000a);
        osc_en <= 1'b0;
        osc_run <= 1'b0;
        wr(stc_pkg::ADDR_CONTROL, 8'h00);
        chk(18'({prd, oen}), 18'hc);
        wr(stc_pkg::ADDR_COUNT_HI, 8'hff);
        wr(stc_pkg::ADDR_COUNT_LO, 8'hfc);
        wr(stc_pkg::ADDR_CONTROL, 8'h01);
        repeat (30) @(posedge clk);
        wr(stc_pkg::ADDR_CONTROL, 8'h00);
        chk(18'({flag, irq, count[15:4]}), 18'h2000);
        wr(stc_pkg::ADDR_IRQ, 8'h03);
        chk(18'(irq), 18'h1);
        wr(stc_pkg::ADDR_IRQ, 8'h00);
        wr(stc_pkg::ADDR_CONTROL, 8'h80);
        wr(stc_pkg::ADDR_COUNT_HI, 8'h12);
        chk(18'(count[15:8]), 18'h0);
        wr(stc_pkg::ADDR_COUNT_LO, 8'h34);
        chk(18'(count), 18'h1234);
        wr(stc_pkg::ADDR_COUNT_HI, 8'h77);
        rd(stc_pkg::ADDR_COUNT_HI, d);
        chk(18'({d, count[15:8]}), 18'h7712);
        rd(stc_pkg::ADDR_COUNT_LO, d);
        rd(stc_pkg::ADDR_COUNT_HI, d);
        chk(18'(d), 18'h12);
        wr(stc_pkg::ADDR_CONTROL, 8'h00);
        wr(stc_pkg::ADDR_COUNT_HI, 8'haa);
        chk(18'(count), 18'haa34);
        wr(stc_pkg::ADDR_CONTROL, 8'h48);
        {m1, m2, adc_en} <= {4'hb, 4'hb, 1'b1};
        fire(1'b1, 1'b0, 1'b0);
        chk({count, flag, adcs}, 18'h0);
        fire(1'b1, 1'b0, 1'b1);
        chk(18'(count), 18'h5a);
        fire(1'b0, 1'b1, 1'b0);
        chk(18'({count, adcs}), 18'h1);
        fire(1'b0, 1'b0, 1'b1);
        @(posedge clk);
        m1 <= 4'ha;
        fire(1'b1, 1'b0, 1'b0);
        chk(18'(count), 18'h5a);
        wrap_up;
    end
endmodule // stc_timer_tb
